// ---- include/smio_pkg.sv ----
// Purpose: Shared constants and carrier types for the manual-setup discrete I/O block.
// Assumes: 10 MHz system clock, synchronous active-high reset.
// Notes:   Pin groups travel as packed structs.
package smio_pkg;
    localparam logic [1:0]  IO_MODE_MANUAL_SETUP = 2'h2;
    localparam int          LIST_SEL_W           = 6;
    localparam int          POS_W                = 32;
    localparam int          LIST_DEPTH           = 64;
    localparam logic [1:0]  SPEED_SLOW           = 2'h1;
    localparam logic [1:0]  SPEED_FAST           = 2'h2;
    localparam int          STANDSTILL_NS        = 1000;
    localparam int          CLK_PERIOD_NS        = 100;
    localparam int          STANDSTILL_CYC       = (STANDSTILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  STANDSTILL_CYC_W     = 4'(STANDSTILL_CYC);

    typedef struct packed {
        logic                  fieldbus_mode_select;
        logic [LIST_SEL_W-1:0] list_select;
        logic                  jog_positive;
        logic                  jog_negative;
        logic                  jog_speed_select;
        logic                  fault_reset;
        logic                  teach_in;
        logic                  amp_enable;
        logic                  ref_switch_n;
        logic                  positive_limit_n;
        logic                  negative_limit_n;
        logic                  stop_n;
    } smio_pins_t;

    typedef struct packed {
        logic mode_select_ack;
        logic job_extra_info;
        logic job_done;
        logic job_error;
        logic drive_ready;
        logic motor_energised;
    } smio_status_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_JOG  = 4'h2,
        ST_BRK  = 4'h4,
        ST_ERR  = 4'h8
    } smio_state_t;
endpackage : smio_pkg

// ---- verilog/smio_core.sv ----
// Purpose: Fixed-assignment manual-setup discrete I/O of a servo drive controller.
// Assumes: Pins are asynchronous and pass two flip-flops; setpoint comes from the drive core.
// Notes:   Jog motion is reported as direction and speed commands; position loop is outside.
// Notes on behaviour
// - This fixed pin map is active only while the I/O configuration value is 2; reference, jog-speed and fault-reset inputs act in any mode.
// - The mode-select level chooses manual jog and teach-in (0) or field-bus control (1).
// - The mode acknowledge output goes high once field-bus control (1) has been adopted and stays low in manual mode.
// - Six list-select inputs form a binary number, weight 1 as bit 0 up to weight 32 as bit 5.
// - In manual mode a rising teach-in trigger stores the current setpoint at the selected list entry.
// - In manual mode jog-positive runs clockwise, jog-negative anticlockwise, slow or fast.
// - The power amplifier is enabled while the enable input is high outside the error state, and locked while low.
// - Limit, reference and stop inputs are active low; limits block their direction, stop halts.
// - Every signal has a fixed function and position with no remapping in this mode.
`timescale 1ns/1ps
`default_nettype none
module smio_core
    import smio_pkg::*;
#(
    parameter int DEPTH = LIST_DEPTH
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Configuration and drive core
    input  wire logic [1:0]             io_mode,
    input  wire logic [POS_W-1:0]       setpoint_pos,
    input  wire logic                   drive_fault,
    // Discrete pins
    input  wire smio_pins_t             pins,
    output smio_status_t                status,
    // Motion command
    output logic                        jog_cw,
    output logic                        jog_ccw,
    output logic [1:0]                  jog_speed,
    output logic                        fieldbus_active,
    output logic                        amp_on,
    output logic                        ref_hit,
    // List memory read port
    input  wire logic [LIST_SEL_W-1:0]  list_rd_addr,
    output logic [POS_W-1:0]            list_rd_data
);
    smio_pins_t  meta_q;
    smio_pins_t  sync_q;
    smio_state_t state_q;
    logic        teach_d1_q;
    logic [3:0]  still_cnt_q;
    logic [POS_W-1:0] list_mem [DEPTH];

    // Two stages, since every pin is asynchronous to clk.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    logic map_on;
    logic manual;
    logic stop_act;
    logic lim_p_act;
    logic lim_n_act;
    logic want_cw;
    logic want_ccw;
    logic teach_rise;
    logic jog_ok;
    assign map_on     = (io_mode == IO_MODE_MANUAL_SETUP);
    assign manual     = map_on && !sync_q.fieldbus_mode_select;
    assign stop_act   = !sync_q.stop_n;
    assign lim_p_act  = !sync_q.positive_limit_n;
    assign lim_n_act  = !sync_q.negative_limit_n;
    assign want_cw    = sync_q.jog_positive && !sync_q.jog_negative && !lim_p_act;
    assign want_ccw   = sync_q.jog_negative && !sync_q.jog_positive && !lim_n_act;
    assign teach_rise = sync_q.teach_in && !teach_d1_q;
    // Jog also needs manual mode and an enabled amplifier at the same edge.
    // Without that, a hand-over to the field bus or a lock leaves one extra cycle of motion.
    assign jog_ok     = (state_q == ST_JOG) && manual && sync_q.amp_enable && !stop_act;

    // Current may flow only in this pin map and outside the error state.
    function automatic logic amp_allowed(input logic        map_act,
                                         input logic        en,
                                         input smio_state_t st);
        return map_act && en && (st != ST_ERR);
    endfunction : amp_allowed

    // Jog state machine; a blocked or stopped jog ends the job at standstill.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            still_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (drive_fault) state_q <= ST_ERR;
                    else if (manual && sync_q.amp_enable && !stop_act && (want_cw || want_ccw))
                        state_q <= ST_JOG;
                end
                ST_JOG: begin
                    if (drive_fault) state_q <= ST_ERR;
                    else if (!manual || !sync_q.amp_enable || stop_act || !(want_cw || want_ccw)) begin
                        state_q     <= ST_BRK;
                        still_cnt_q <= STANDSTILL_CYC_W;
                    end
                end
                ST_BRK: begin
                    if (drive_fault) state_q <= ST_ERR;
                    else if (still_cnt_q <= 4'h1) state_q <= ST_IDLE;
                    else still_cnt_q <= still_cnt_q - 4'h1;
                end
                ST_ERR: begin
                    if (sync_q.fault_reset && !drive_fault) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Teach-in: list memory holds the setpoint captured per entry.
    always_ff @(posedge clk) begin
        if (rst) teach_d1_q <= 1'b0;
        else teach_d1_q <= sync_q.teach_in;
    end

    always_ff @(posedge clk) begin
        if (!rst && manual && teach_rise)
            list_mem[sync_q.list_select] <= setpoint_pos;
    end

    always_ff @(posedge clk) begin
        if (rst) list_rd_data <= '0;
        else list_rd_data <= list_mem[list_rd_addr];
    end

    // Registered outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            status          <= '0;
            jog_cw          <= 1'b0;
            jog_ccw         <= 1'b0;
            jog_speed       <= '0;
            fieldbus_active <= 1'b0;
            amp_on          <= 1'b0;
            ref_hit         <= 1'b0;
        end else begin
            status.mode_select_ack <= map_on && sync_q.fieldbus_mode_select;
            fieldbus_active        <= map_on && sync_q.fieldbus_mode_select;
            amp_on                 <= amp_allowed(map_on, sync_q.amp_enable, state_q);
            ref_hit                <= !sync_q.ref_switch_n;
            jog_cw                 <= jog_ok && want_cw;
            jog_ccw                <= jog_ok && want_ccw;
            jog_speed              <= sync_q.jog_speed_select ? SPEED_FAST : SPEED_SLOW;
            status.job_extra_info  <= (state_q == ST_JOG) && sync_q.jog_speed_select;
            status.job_done        <= (state_q == ST_IDLE);
            status.job_error       <= (state_q == ST_ERR);
            status.drive_ready     <= map_on && state_q != ST_ERR;
            status.motor_energised <= amp_allowed(map_on, sync_q.amp_enable, state_q);
        end
    end

    // Assertions.
    property p_ack_follows;
        @(posedge clk) disable iff (rst)
        $rose(sync_q.fieldbus_mode_select) && map_on |=> status.mode_select_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack did not follow mode");

    property p_map_gate;
        @(posedge clk) disable iff (rst)
        !map_on |=> !status.drive_ready && !amp_on;
    endproperty
    a_map_gate: assert property (p_map_gate) else $error("outputs active outside mode 2");

    property p_fb_no_jog;
        @(posedge clk) disable iff (rst)
        sync_q.fieldbus_mode_select |=> !jog_cw && !jog_ccw;
    endproperty
    a_fb_no_jog: assert property (p_fb_no_jog) else $error("jog in field-bus mode");

    property p_limit_blocks;
        @(posedge clk) disable iff (rst)
        lim_p_act |=> !jog_cw;
    endproperty
    a_limit_blocks: assert property (p_limit_blocks) else $error("cw jog past limit");

    property p_stop_halts;
        @(posedge clk) disable iff (rst)
        stop_act |=> !jog_cw && !jog_ccw;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("jog while stopped");

    property p_amp_lock;
        @(posedge clk) disable iff (rst)
        !sync_q.amp_enable |=> !amp_on ##1 !jog_cw;
    endproperty
    a_amp_lock: assert property (p_amp_lock) else $error("amplifier on while locked");

    property p_jog_lock;
        @(posedge clk) disable iff (rst)
        (!sync_q.amp_enable || !manual) |=> !jog_cw && !jog_ccw;
    endproperty
    a_jog_lock: assert property (p_jog_lock) else $error("jog while locked");

    property p_speed;
        @(posedge clk) disable iff (rst)
        sync_q.jog_speed_select |=> jog_speed == SPEED_FAST;
    endproperty
    a_speed: assert property (p_speed) else $error("speed select ignored");

    property p_err_flag;
        @(posedge clk) disable iff (rst)
        drive_fault && state_q != ST_ERR |=> ##1 status.job_error;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("job error not raised");

    property p_reset_clears;
        @(posedge clk) disable iff (rst)
        state_q == ST_ERR && sync_q.fault_reset && !drive_fault |=> ##1 !status.job_error;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("fault reset ignored");

    property p_teach_store;
        @(posedge clk) disable iff (rst)
        manual && teach_rise |=> list_mem[$past(sync_q.list_select)] == $past(setpoint_pos);
    endproperty
    a_teach_store: assert property (p_teach_store) else $error("teach-in not stored");
endmodule : smio_core
`default_nettype wire

// ---- test/smio_ctrl_model.sv ----
// Purpose: Machine controller that drives the discrete pins of the block.
// Assumes: Pins change only at the falling clock edge.
// Notes:   Idle leaves all active-low switches released.
`timescale 1ns/1ps
`default_nettype none
module smio_ctrl_model
    import smio_pkg::*;
(
    // Clock and pins
    input  wire logic clk,
    output smio_pins_t pins
);
    initial pins = 17'h0000F;
    // Whole pin word changes at once, as a wired controller does.
    task automatic set(input smio_pins_t p);
        @(negedge clk);
        pins = p;
    endtask : set
endmodule : smio_ctrl_model
`default_nettype wire

// ---- test/test_servo_manual_setup_io.sv ----
// Purpose: Self-checking bench for the manual-setup discrete I/O.
// Assumes: Three-cycle latency from a pin change to the outputs, four for outputs that follow the jog state.
// Notes:   Outputs are sampled at the falling edge, where they are settled.
`timescale 1ns/1ps
`default_nettype none
module test_servo_manual_setup_io
    import smio_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic [1:0]            io_mode = 2'h0;
    logic [POS_W-1:0]      setpoint_pos = 32'h0;
    logic                  drive_fault = 1'b0;
    logic [LIST_SEL_W-1:0] list_rd_addr = 6'h00;
    smio_pins_t            pins, p;
    smio_status_t          status;
    logic                  jog_cw, jog_ccw, fieldbus_active, amp_on, ref_hit;
    logic [1:0]            jog_speed;
    logic [POS_W-1:0]      list_rd_data;
    int                    n_mismatch = 0;
    int                    n_compared = 0;
    always #50 clk = ~clk;
    smio_ctrl_model ctrl_model_i (.clk(clk), .pins(pins));
    smio_core smio_core_i (.clk(clk), .rst(rst), .io_mode(io_mode),
        .setpoint_pos(setpoint_pos), .drive_fault(drive_fault), .pins(pins),
        .status(status), .jog_cw(jog_cw), .jog_ccw(jog_ccw), .jog_speed(jog_speed),
        .fieldbus_active(fieldbus_active), .amp_on(amp_on), .ref_hit(ref_hit),
        .list_rd_addr(list_rd_addr), .list_rd_data(list_rd_data));
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic bit_is(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : bit_is
    task automatic word_is(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : word_is
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic apply;
        ctrl_model_i.set(p);
        cyc(5);
    endtask : apply
    task automatic t_reset;
        cyc(12);
        bit_is("status in reset", 1'b0, |status);
        rst = 1'b0;
        cyc(4);
        p = pins;
        p.amp_enable = 1'b1;
        p.jog_positive = 1'b1;
        apply();
        bit_is("jog_cw off map", 1'b0, jog_cw);
        bit_is("drive_ready off map", 1'b0, status.drive_ready);
        bit_is("motor_energised off map", 1'b0, status.motor_energised);
        p.jog_positive = 1'b0;
        apply();
        $display("test reset done");
    endtask : t_reset
    task automatic t_jog;
        int i;
        io_mode = IO_MODE_MANUAL_SETUP;
        apply();
        bit_is("amp_on", 1'b1, amp_on);
        bit_is("drive_ready", 1'b1, status.drive_ready);
        bit_is("motor_energised", 1'b1, status.motor_energised);
        bit_is("mode ack manual", 1'b0, status.mode_select_ack);
        p.jog_positive = 1'b1;
        p.jog_speed_select = 1'b1;
        apply();
        bit_is("jog_cw", 1'b1, jog_cw);
        bit_is("jog_ccw", 1'b0, jog_ccw);
        word_is("speed fast", 32'(SPEED_FAST), 32'(jog_speed));
        bit_is("job_extra_info fast", 1'b1, status.job_extra_info);
        bit_is("job_done busy", 1'b0, status.job_done);
        p.jog_positive = 1'b0;
        ctrl_model_i.set(p);
        for (i = 0; i < 40 && status.job_done !== 1'b1; i++) cyc(1);
        bit_is("job_done end", 1'b1, status.job_done);
        if (status.job_done !== 1'b1) give_verdict();
        p.jog_speed_select = 1'b0;
        p.jog_negative = 1'b1;
        apply();
        bit_is("jog_ccw", 1'b1, jog_ccw);
        word_is("speed slow", 32'(SPEED_SLOW), 32'(jog_speed));
        bit_is("job_extra_info slow", 1'b0, status.job_extra_info);
        p.negative_limit_n = 1'b0;
        apply();
        bit_is("jog_ccw limit", 1'b0, jog_ccw);
        p.negative_limit_n = 1'b1;
        apply();
        cyc(8);
        bit_is("jog_ccw limit gone", 1'b1, jog_ccw);
        p.stop_n = 1'b0;
        p.ref_switch_n = 1'b0;
        apply();
        bit_is("jog_ccw stop", 1'b0, jog_ccw);
        bit_is("ref_hit", 1'b1, ref_hit);
        p.stop_n = 1'b1;
        apply();
        cyc(8);
        bit_is("jog_ccw stop gone", 1'b1, jog_ccw);
        p.amp_enable = 1'b0;
        apply();
        bit_is("jog_ccw amp off", 1'b0, jog_ccw);
        bit_is("amp_on off", 1'b0, amp_on);
        bit_is("motor_energised off", 1'b0, status.motor_energised);
        p = 17'h0001F;
        apply();
        bit_is("ref_hit released", 1'b0, ref_hit);
        $display("test jog done");
    endtask : t_jog
    task automatic t_teach;
        setpoint_pos = 32'hA5C30F1E;
        p.list_select = 6'h0B;
        p.teach_in = 1'b1;
        apply();
        p.teach_in = 1'b0;
        p.fieldbus_mode_select = 1'b1;
        apply();
        setpoint_pos = 32'h12345678;
        p.teach_in = 1'b1;
        list_rd_addr = 6'h0B;
        apply();
        word_is("list entry", 32'hA5C30F1E, list_rd_data);
        bit_is("fieldbus_active", 1'b1, fieldbus_active);
        bit_is("mode ack", 1'b1, status.mode_select_ack);
        p = 17'h0001F;
        apply();
        $display("test teach done");
    endtask : t_teach
    task automatic t_fault;
        drive_fault = 1'b1;
        cyc(4);
        bit_is("job_error", 1'b1, status.job_error);
        bit_is("drive_ready in error", 1'b0, status.drive_ready);
        bit_is("amp_on in error", 1'b0, amp_on);
        drive_fault = 1'b0;
        p.fault_reset = 1'b1;
        apply();
        bit_is("job_error clear", 1'b0, status.job_error);
        bit_is("drive_ready again", 1'b1, status.drive_ready);
        $display("test fault done");
    endtask : t_fault
    initial begin
        p = 17'h0000F;
        t_reset();
        t_jog();
        t_teach();
        t_fault();
        give_verdict();
    end
endmodule : test_servo_manual_setup_io
`default_nettype wire
